// [pkg/arss_map.svh]
// Constants for the accumulator round, store saturate and shift datapath
`ifndef ARSS_MAP_SVH
`define ARSS_MAP_SVH

`define ARSS_ACC_W 40
`define ARSS_WORD_W 16
`define ARSS_SHAMT_W 6
`define ARSS_SIGN_BIT 39
`define ARSS_GUARD_LO 32
`define ARSS_HI_LO 16
`define ARSS_RND_BIT 15
`define ARSS_LOW_HALF 16'h8000
`define ARSS_MAX_POS 16'h7fff
`define ARSS_MAX_NEG 16'h8000
`define ARSS_MAX_SHIFT 16
`define ARSS_CTRL_RND_POS 1
`define ARSS_CTRL_STORE_SATURATE_ENABLE_POS 5

`endif

// [pkg/arss_pkg.sv]
// Types for the accumulator round, store saturate and shift datapath
package arss_pkg;
  typedef enum logic [1:0] {
    ARSS_SRC_ACC_A = 2'h0,
    ARSS_SRC_ACC_B = 2'h1,
    ARSS_SRC_XBUS = 2'h2
  } arss_src_t;

  typedef enum logic [1:0] {
    ARSS_SH_ARITH = 2'h0,
    ARSS_SH_LOGIC = 2'h1
  } arss_shkind_t;

  typedef enum logic [2:0] {
    ARSS_ST_IDLE = 3'b001,
    ARSS_ST_STORE = 3'b010,
    ARSS_ST_SHIFT = 3'b100
  } arss_state_t;
endpackage : arss_pkg

// [verilog/arss_shifter.sv]
// Forty-bit one-cycle barrel shifter with signed shift amount
`timescale 1ns/1ps
`include "arss_map.svh"
module arss_shifter (
  input wire logic [39:0] operand_i,
  input wire logic signed [5:0] amount_i,
  input wire logic arith_i,
  output logic [39:0] result_o
);
  logic [5:0] mag;
  logic neg;
  logic [39:0] fill;
  logic [79:0] ext;
  logic [79:0] ext_sh;
  assign neg = amount_i[5];
  assign mag = neg ? 6'(-amount_i) : amount_i;
  // Sign fill only on arithmetic right shifts
  assign fill = (arith_i && operand_i[`ARSS_SIGN_BIT]) ? {40{1'b1}} : '0;
  assign ext = {fill, operand_i};
  assign ext_sh = ext >> mag;
  // Zero in from the right on left shifts
  assign result_o = (mag == 6'h0) ? operand_i :
                    neg ? (operand_i << mag) : ext_sh[39:0];
endmodule : arss_shifter

// [verilog/arss_datapath.sv]
// Accumulator round, store saturation and barrel shift datapath
`timescale 1ns/1ps
`include "arss_map.svh"
module arss_datapath
  import arss_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [15:0] core_control_reg_i,
  input wire logic [39:0] accum_a_i,
  input wire logic [39:0] accum_b_i,
  input wire logic store_req_i,
  input wire logic store_acc_b_i,
  input wire logic store_accum_truncated_i,
  input wire logic store_accum_rounded_i,
  input wire logic multiply_accumulate_class_i,
  input wire logic shift_req_i,
  input wire arss_pkg::arss_src_t shift_src_i,
  input wire arss_pkg::arss_shkind_t shift_kind_i,
  input wire logic signed [5:0] shift_amount_i,
  input wire logic [15:0] xbus_rd_i,
  output logic [15:0] xbus_wr_data_o,
  output logic xbus_wr_en_o,
  output logic store_saturated_o,
  output logic [15:0] store_value_o,
  output logic [39:0] shift_acc_result_o,
  output logic [15:0] shift_word_result_o,
  output logic shift_valid_o
);
  import arss_pkg::*;

  // ******************************************************
  // Store path: operand select and round stage
  // ******************************************************
  logic round_mode_select;
  logic store_saturate_enable;
  logic [39:0] store_src;
  logic [15:0] accum_high_word;
  logic [15:0] accum_low_word;
  logic do_round;
  logic tie;
  logic round_inc;
  logic [16:0] round_sum;
  logic round_ovf;
  logic [15:0] round_val;

  assign round_mode_select = core_control_reg_i[`ARSS_CTRL_RND_POS];
  assign store_saturate_enable = core_control_reg_i[`ARSS_CTRL_STORE_SATURATE_ENABLE_POS];
  assign store_src = store_acc_b_i ? accum_b_i : accum_a_i;
  assign accum_high_word = store_src[31:`ARSS_HI_LO];
  assign accum_low_word = store_src[15:0];
  // Write-back of the multiply class ignores the truncate request
  assign do_round = multiply_accumulate_class_i ||
                    (store_accum_rounded_i && !store_accum_truncated_i);
  assign tie = (accum_low_word == `ARSS_LOW_HALF);
  // Convergent mode replaces the tie increment by bit 16
  assign round_inc = (round_mode_select && tie) ?
                     store_src[`ARSS_HI_LO] :
                     store_src[`ARSS_RND_BIT];
  // Purely combinational, used in the same cycle as the store
  assign round_sum = {1'b0, accum_high_word} + {16'h0, round_inc};
  // Adder overflow: positive high word wrapping to negative
  assign round_ovf = do_round && round_inc &&
                     (accum_high_word == `ARSS_MAX_POS);
  assign round_val = do_round ? round_sum[15:0] : accum_high_word;

  // ******************************************************
  // Store path: data space write saturation
  // ******************************************************
  logic sign_neg;
  logic guard_pos_ovf;
  logic guard_neg_ovf;
  logic sat_pos;
  logic sat_neg;
  logic [15:0] sat_val;

  // Sign taken from the accumulator, not from the rounded word
  assign sign_neg = store_src[`ARSS_SIGN_BIT];
  // Value above 0x007fff: positive with guard or bit 31 set, or adder wrap
  assign guard_pos_ovf = (store_src[39:`ARSS_GUARD_LO] != 8'h00) ||
                         store_src[31] || round_ovf;
  // Value below 0xff8000: negative with guard or bit 31 clear
  assign guard_neg_ovf = (store_src[39:`ARSS_GUARD_LO] != 8'hff) ||
                         !store_src[31];
  assign sat_pos = store_saturate_enable && !sign_neg && guard_pos_ovf;
  assign sat_neg = store_saturate_enable && sign_neg && guard_neg_ovf;
  // Clamping touches only the store copy, never the accumulator
  assign sat_val = sat_pos ? `ARSS_MAX_POS :
                   sat_neg ? `ARSS_MAX_NEG :
                   round_val;
  assign store_value_o = sat_val;

  // ******************************************************
  // Shift path
  // ******************************************************
  logic [39:0] sh_operand;
  logic [39:0] sh_result;
  logic sh_right;
  logic [39:0] xbus_placed;

  assign sh_right = !shift_amount_i[5];
  // X bus data sits at 31:16 for right shifts and low for left
  assign xbus_placed = sh_right ? {8'h00, xbus_rd_i, 16'h0000} :
                                  {24'h000000, xbus_rd_i};
  assign sh_operand = (shift_src_i == ARSS_SRC_ACC_A) ? accum_a_i :
                      (shift_src_i == ARSS_SRC_ACC_B) ? accum_b_i :
                      xbus_placed;

  arss_shifter u_shifter (
    .operand_i(sh_operand),
    .amount_i(shift_amount_i),
    .arith_i(shift_kind_i == ARSS_SH_ARITH),
    .result_o(sh_result)
  );

  logic [15:0] sh_word;
  // Word result comes from where the operand was placed
  assign sh_word = sh_right ? sh_result[31:16] : sh_result[15:0];

  // ******************************************************
  // Output registers
  // ******************************************************
  arss_state_t state_reg;
  arss_state_t state_next;
  logic [15:0] wr_data_reg;
  logic sat_reg;
  logic [39:0] acc_res_reg;
  logic [15:0] word_res_reg;

  // Store takes priority if both arrive together
  assign state_next = store_req_i ? ARSS_ST_STORE :
                      shift_req_i ? ARSS_ST_SHIFT : ARSS_ST_IDLE;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_reg <= ARSS_ST_IDLE;
      wr_data_reg <= 16'h0000;
      sat_reg <= 1'b0;
      acc_res_reg <= 40'h0;
      word_res_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (store_req_i) begin
        wr_data_reg <= sat_val;
        sat_reg <= sat_pos || sat_neg;
      end
      if (shift_req_i && !store_req_i) begin
        acc_res_reg <= sh_result;
        word_res_reg <= sh_word;
      end
    end
  end

  logic wr_en;
  logic sh_valid;
  always_comb begin
    wr_en = 1'b0;
    sh_valid = 1'b0;
    case (state_reg)
      ARSS_ST_IDLE: begin
        wr_en = 1'b0;
      end
      ARSS_ST_STORE: begin
        wr_en = 1'b1;
      end
      ARSS_ST_SHIFT: begin
        sh_valid = 1'b1;
      end
      default: begin
        wr_en = 1'b0;
      end
    endcase
  end

  assign xbus_wr_data_o = wr_data_reg;
  assign xbus_wr_en_o = wr_en;
  assign store_saturated_o = sat_reg;
  assign shift_acc_result_o = acc_res_reg;
  assign shift_word_result_o = word_res_reg;
  assign shift_valid_o = sh_valid;
endmodule : arss_datapath

// [bench/arss_core_model.sv]
// Core side model: one data word written and read back over the X bus
`timescale 1ns/1ps
module arss_core_model (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic wr_en_i,
  input wire logic [15:0] wr_data_i,
  output logic [15:0] rd_data_o
);
  // Reads return the last stored word, so shifts see real memory data
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) rd_data_o <= 16'h0;
    else if (wr_en_i) rd_data_o <= wr_data_i;
  end
endmodule : arss_core_model

// [bench/arss_datapath_asserts.sv]
// Checker of store and shift timing and values at the ports
`timescale 1ns/1ps
module arss_datapath_asserts
  import arss_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [15:0] core_control_reg_i,
  input wire logic [39:0] accum_a_i,
  input wire logic [39:0] accum_b_i,
  input wire logic store_req_i,
  input wire logic store_acc_b_i,
  input wire logic multiply_accumulate_class_i,
  input wire logic shift_req_i,
  input wire arss_pkg::arss_src_t shift_src_i,
  input wire logic signed [5:0] shift_amount_i,
  input wire logic [15:0] xbus_wr_data_o,
  input wire logic xbus_wr_en_o,
  input wire logic [15:0] store_value_o,
  input wire logic [39:0] shift_acc_result_o,
  input wire logic shift_valid_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  wire [39:0] src = store_acc_b_i ? accum_b_i : accum_a_i;
  wire sat = core_control_reg_i[5];
  wire go = shift_req_i && !store_req_i;
  a_store_strobe: assert property (store_req_i |=> xbus_wr_en_o)
    else $error("no store strobe");
  a_no_stray: assert property (!store_req_i |=> !xbus_wr_en_o)
    else $error("stray store strobe");
  a_write_view: assert property (store_req_i |=>
    xbus_wr_data_o == $past(store_value_o)) else $error("store data");
  a_mac_rounds: assert property (multiply_accumulate_class_i && !sat &&
    !core_control_reg_i[1] |-> store_value_o == src[31:16] + src[15])
    else $error("mac not rounded");
  a_clamp_pos: assert property (sat && !src[39] && src[38:31] != 0
    |-> store_value_o == 16'h7fff) else $error("no positive clamp");
  a_clamp_neg: assert property (sat && src[39] && src[38:31] != 8'hff
    |-> store_value_o == 16'h8000) else $error("no negative clamp");
  a_shift_done: assert property (go |=> shift_valid_o)
    else $error("shift not done");
  a_shift_drop: assert property (!go |=> !shift_valid_o)
    else $error("stray shift valid");
  a_zero_shift: assert property (go && shift_amount_i == 0 &&
    shift_src_i == ARSS_SRC_ACC_A |=> shift_acc_result_o == $past(accum_a_i))
    else $error("zero shift changed operand");
  c_store: cover property (store_req_i ##1 xbus_wr_en_o);
  c_clamp: cover property (sat && store_value_o == 16'h7fff);
  c_shift: cover property (go ##1 shift_valid_o);
endmodule : arss_datapath_asserts
bind arss_datapath arss_datapath_asserts i_chk(.clk_sys_i, .nrst_i,
  .core_control_reg_i, .accum_a_i, .accum_b_i, .store_req_i, .store_acc_b_i,
  .multiply_accumulate_class_i, .shift_req_i, .shift_src_i, .shift_amount_i,
  .xbus_wr_data_o, .xbus_wr_en_o, .store_value_o, .shift_acc_result_o,
  .shift_valid_o);

// [bench/accumulator_round_saturate_shift_test.sv]
// Self-checking bench for the round, saturate and shift datapath
`timescale 1ns/1ps
module accumulator_round_saturate_shift_test;
  import arss_pkg::*;
  logic clk = 0, nrst = 0, sreq = 0, bsel = 0, tr = 0, rr = 0, mac = 0;
  logic shreq = 0, wen, ssat, shv;
  logic [15:0] ctrl = 0, xrd, wdat, sval, wres, last;
  logic [39:0] acc_a = 0, acc_b = 0, sres;
  arss_src_t src = ARSS_SRC_ACC_A;
  arss_shkind_t kind = ARSS_SH_ARITH;
  logic signed [5:0] amt = 0;
  int mismatches = 0, n_compared = 0;
  initial forever #20 clk = ~clk;
  arss_datapath i_dut(.clk_sys_i(clk), .nrst_i(nrst),
    .core_control_reg_i(ctrl), .accum_a_i(acc_a), .accum_b_i(acc_b),
    .store_req_i(sreq), .store_acc_b_i(bsel), .store_accum_truncated_i(tr),
    .store_accum_rounded_i(rr), .multiply_accumulate_class_i(mac),
    .shift_req_i(shreq), .shift_src_i(src), .shift_kind_i(kind),
    .shift_amount_i(amt), .xbus_rd_i(xrd), .xbus_wr_data_o(wdat),
    .xbus_wr_en_o(wen), .store_saturated_o(ssat), .store_value_o(sval),
    .shift_acc_result_o(sres), .shift_word_result_o(wres),
    .shift_valid_o(shv));
  arss_core_model i_core(.clk_sys_i(clk), .nrst_i(nrst), .wr_en_i(wen),
    .wr_data_i(wdat), .rd_data_o(xrd));
  task automatic chk(string nm, logic [39:0] e, logic [39:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic stop_test;
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // Kind 0 truncates, 1 rounds from B, 2 is multiply class with truncate set
  task automatic st(logic cv, logic sat, int k, logic [39:0] a);
    logic [15:0] s;
    logic inc, p, n;
    inc = k > 0 && a[15] && !(cv && a[15:0] == 16'h8000 && !a[16]);
    s = a[31:16] + 16'(inc);
    p = !a[39] && (a[38:31] != 0 || (inc && s == 16'h8000));
    n = a[39] && a[38:31] != 8'hff;
    if (sat && (p || n)) s = p ? 16'h7fff : 16'h8000;
    @(posedge clk);
    {sreq, tr, rr, mac, bsel} <= {1'b1, k != 1, k == 1, k == 2, k == 1};
    ctrl <= {10'h0, sat, 3'h0, cv, 1'b0};
    acc_a <= k == 1 ? ~a : a;
    acc_b <= k == 1 ? a : ~a;
    #1 chk("store view", s, sval);
    @(posedge clk);
    sreq <= 0;
    #1 chk("store strobe", 1, wen);
    chk("store data", s, wdat);
    chk("clamp flag", sat && (p || n), ssat);
    last = s;
  endtask : st
  task automatic sh(arss_src_t sc, arss_shkind_t kd, int n, logic [39:0] op);
    logic [39:0] e;
    logic signed [39:0] so;
    if (sc == ARSS_SRC_XBUS) op = n > 0 ? {8'h0, last, 16'h0} : {24'h0, last};
    so = op;
    so = so >>> n;
    if (n <= 0) e = op << -n;
    else e = kd == ARSS_SH_LOGIC ? op >> n : so;
    @(posedge clk);
    shreq <= 1'b1;
    src <= sc;
    kind <= kd;
    amt <= 6'(n);
    acc_a <= sc == ARSS_SRC_ACC_B ? ~op : op;
    acc_b <= sc == ARSS_SRC_ACC_B ? op : ~op;
    @(posedge clk);
    shreq <= 0;
    #1 chk("shift valid", 1, shv);
    if (sc == ARSS_SRC_XBUS) chk("word", n > 0 ? e[31:16] : e[15:0], wres);
    else chk("shift acc", e, sres);
  endtask : sh
  task automatic drop;
    @(posedge clk);
    {sreq, shreq} <= 2'h3;
    @(posedge clk);
    {sreq, shreq} <= 2'h0;
    #1 chk("shift dropped", 0, shv);
  endtask : drop
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1;
    st(0, 0, 1, 40'h00_1234_7fff);
    st(0, 0, 1, 40'h00_1234_8000);
    st(1, 0, 1, 40'h00_1234_8000);
    st(1, 0, 1, 40'h00_1235_8000);
    st(0, 0, 0, 40'h00_1234_ffff);
    st(0, 0, 2, 40'h00_1234_ffff);
    st(0, 1, 1, 40'h00_7fff_8000);
    st(0, 1, 0, 40'h01_0000_0000);
    st(0, 1, 0, 40'hff_7fff_0000);
    st(0, 1, 0, 40'hff_8000_0000);
    st(0, 0, 0, 40'h01_0000_0000);
    st(0, 0, 0, 40'h00_1234_0000);
    sh(ARSS_SRC_XBUS, ARSS_SH_LOGIC, 4, 0);
    sh(ARSS_SRC_XBUS, ARSS_SH_LOGIC, -3, 0);
    sh(ARSS_SRC_ACC_A, ARSS_SH_ARITH, 16, 40'h80_1234_5678);
    sh(ARSS_SRC_ACC_B, ARSS_SH_LOGIC, 16, 40'h80_1234_5678);
    sh(ARSS_SRC_ACC_A, ARSS_SH_ARITH, -16, 40'h80_1234_5678);
    sh(ARSS_SRC_ACC_A, ARSS_SH_ARITH, 0, 40'h80_1234_5678);
    sh(ARSS_SRC_ACC_B, ARSS_SH_ARITH, 1, 40'h7f_0000_0001);
    drop();
    stop_test;
  end
  // About 46 cycles of work, so 20 us only trips on a hang
  initial begin
    #20000;
    mismatches++;
    stop_test;
  end
endmodule : accumulator_round_saturate_shift_test
